//--- dv/slmon_peer.sv
// Remote signalling link terminal model that feeds received units, status and acks.
`timescale 1ns/1ns
module slmon_peer import slmon_pkg::*; (
  input wire logic i_sys_clk,
  output logic o_good,
  output logic o_err,
  output logic o_oct,
  output logic o_loss,
  output slmon_lssu_t o_lssu,
  output logic [2:0] o_ack
);
  initial begin
    {o_good, o_err, o_oct, o_loss, o_ack} = 7'h00;
    o_lssu = '0;
  end
  task automatic burst(input int kind, input int n);
    @(posedge i_sys_clk);
    {o_good, o_err, o_oct, o_loss} <= 4'h8 >> kind;
    repeat (n) @(posedge i_sys_clk);
    {o_good, o_err, o_oct, o_loss} <= 4'h0;
  endtask
  task automatic status(input logic [5:0] li, input logic [2:0] code);
    @(posedge i_sys_clk);
    o_lssu <= {1'h1, li, 13'($urandom), code};
    @(posedge i_sys_clk);
    o_lssu <= {1'h0, ~o_lssu.li, ~o_lssu.sf};
  endtask
  task automatic ack(input logic pos, input logic covers);
    @(posedge i_sys_clk);
    o_ack <= {1'h1, pos, covers};
    @(posedge i_sys_clk);
    o_ack <= {1'h0, ~pos, ~covers};
  endtask
endmodule

//--- dv/slmon_top_tb.sv
// Self-checking testbench for the signalling link error monitor.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module slmon_top_tb import slmon_pkg::*; ;
  localparam int UL = 127;
  localparam int OL = 4096;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, slot = 0, enter = 0, expd = 0;
  logic [7:0] paddr = 0, fill = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [15:0] units = 0, octets = 0;
  slmon_tx_req_t req = '0;
  logic pready, pslverr, good, err, oct, loss, excess, lfail, oos, abrt, rstp, ok, rxv, cong;
  logic [2:0] ack;
  slmon_lssu_t lssu;
  slmon_tx_sel_t tx_sel;
  slmon_status_t rxs;
  int bad_count = 0, checked = 0, cyc = 0, n_abort = 0, n_rst = 0, n_ok = 0, i, seed;
  logic [6:0] t;

  always #50 clk = ~clk;

  slmon_peer i_peer (.i_sys_clk(clk), .o_good(good), .o_err(err), .o_oct(oct), .o_loss(loss),
    .o_lssu(lssu), .o_ack(ack));

  slmon_top #(.BUSY_REPEAT_MS(0), .CONG_SUP_MS(1), .UNIT_LIMIT(UL), .OCTET_LIMIT(OL)) i_dut (
    .i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_su_good(good), .i_su_error(err), .i_octet(oct),
    .i_loss_align(loss), .i_proving_enter(enter), .i_period_expired(expd), .i_lssu(lssu),
    .i_ack_valid(ack[2]), .i_ack_positive(ack[1]), .i_ack_covers(ack[0]), .i_rx_fill(fill),
    .i_tx_slot(slot), .i_tx_req(req), .i_rtb_units(units), .i_rtb_octets(octets),
    .o_tx_sel(tx_sel), .o_excess_error(excess), .o_link_fail(lfail), .o_out_of_service(oos),
    .o_proving_abort(abrt), .o_proving_restart(rstp), .o_proving_ok(ok), .o_rx_status(rxs),
    .o_rx_status_valid(rxv), .o_congested(cong));

  always @(posedge clk) begin
    n_abort += int'(abrt === 1'h1);
    n_rst += int'(rstp === 1'h1);
    n_ok += int'(ok === 1'h1);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic slmon_tx_sel_t exp_sel(slmon_tx_req_t r, logic cy, int u, int o);
    if (r.silent) return TX_IDLE;
    if (r.flags_only) return TX_FLAG;
    if (r.lssu) return TX_LSSU;
    if (!cy && r.repeat_msu) return TX_REPEAT;
    if (!cy && r.nack_msu) return TX_NACK;
    if (cy && r.unacked_msu && (u > UL || o > OL)) return TX_UNACK;
    if (r.new_msu) return TX_NEW;
    if (cy && r.unacked_msu) return TX_UNACK;
    if (r.fisu) return TX_FISU;
    return TX_FLAG;
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = pslverr ? 32'hDEAD_0000 | prdata : prdata;
    {psel, pen} <= 2'h0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ev(input int k);
    @(posedge clk);
    {enter, expd} <= 2'h2 >> k;
    @(posedge clk);
    {enter, expd} <= 2'h0;
    wt(2);
  endtask

  task automatic sel(input slmon_tx_req_t r, input logic cy, input logic busy);
    @(posedge clk);
    {slot, req} <= {1'h1, r};
    units <= 16'($urandom_range(90, 160));
    octets <= 16'($urandom_range(4000, 4200));
    @(posedge clk);
    slot <= 1'h0;
    @(negedge clk);
    `CHK("tx_sel", exp_sel(r | {busy, 7'h00}, cy, units, octets), tx_sel)
  endtask

  initial begin
    seed = $urandom(4162);
    wt(2);
    rstn <= 1'h1;
    apb(0, REG_CTRL, 0);
    `CHK("ctrl", 32'h0000_0002, rdat)
    apb(0, REG_CONG, 0);
    `CHK("cong", 32'h0000_2040, rdat)
    apb(0, 8'h0C, 0);
    `CHK("unmapped", 32'hDEAD_0000, rdat)
    apb(1, REG_CTRL, 32'h0000_0012);
    ev(0);
    ev(1);
    `CHK("ok", 1, n_ok)
    apb(1, REG_CTRL, 32'h0000_0012);
    ev(0);
    for (i = 0; i < 5; i++) begin
      i_peer.burst(1, 3);
      wt(3);
      `CHK("abort", i, n_abort)
      i_peer.burst(1, 1);
      wt(3);
      `CHK("abort", i + 1, n_abort)
      i_peer.burst(0, 1);
      wt(3);
    end
    `CHK("restart", 4, n_rst)
    `CHK("oos", 1'h1, oos)
    apb(1, REG_CTRL, 32'h0000_0016);
    @(negedge clk);
    `CHK("oos", 1'h0, oos)
    ev(0);
    i_peer.burst(1, 1);
    wt(3);
    `CHK("abort", 6, n_abort)
    for (i = 0; i < 2; i++) begin
      t = i ? 7'h20 : 7'h40;
      apb(1, REG_CTRL, i ? 32'h0000_0008 : 32'h0000_000A);
      i_peer.burst(1, t - 1);
      wt(3);
      `CHK("excess", 1'h0, excess)
      i_peer.burst(1, 2);
      wt(3);
      `CHK("excess", 1'h1, excess)
      apb(0, REG_STATUS, 0);
      `CHK("count", t, rdat[6:0])
      i_peer.burst(0, 256);
      wt(3);
      apb(0, REG_STATUS, 0);
      `CHK("count", t - 7'h01, rdat[6:0])
    end
    apb(1, REG_CTRL, 32'h0000_000A);
    i_peer.burst(3, 1);
    i_peer.burst(2, 32);
    i_peer.burst(0, 1);
    i_peer.burst(2, 16);
    wt(3);
    apb(0, REG_STATUS, 0);
    `CHK("count", 7'h02, rdat[6:0])
    for (i = 0; i < 5; i++) begin
      i_peer.status(6'(1 + $urandom_range(0, 1)), 3'(i));
      @(negedge clk);
      `CHK("status", 3'(i), rxs)
      `CHK("status_valid", 1'h1, rxv)
    end
    i_peer.status(6'h03, 3'h2);
    @(negedge clk);
    `CHK("status_valid", 1'h0, rxv)
    for (i = 0; i < 80; i++) begin
      if (i == 0 || i == 40) apb(1, REG_CTRL, i ? 32'h0000_0003 : 32'h0000_0002);
      sel(8'($urandom & $urandom) & (i < 40 ? 8'hF4 : 8'h9C), i >= 40, 0);
    end
    sel(8'h00, 1, 0);
    sel(8'h81, 0, 0);
    sel(8'h82, 1, 0);
    apb(1, REG_CTRL, 32'h0000_0002);
    fill <= 8'h40;
    wt(3);
    `CHK("congested", 1'h1, cong)
    sel(8'h04, 0, 1);
    fill <= 8'h30;
    wt(3);
    `CHK("congested", 1'h1, cong)
    fill <= 8'h20;
    wt(3);
    `CHK("congested", 1'h0, cong)
    sel(8'h04, 0, 0);
    i_peer.status(6'h01, 3'h5);
    wt(3);
    apb(0, REG_STATUS, 0);
    `CHK("supervision", 1'h1, rdat[14])
    i_peer.ack(0, 1);
    wt(3);
    apb(0, REG_STATUS, 0);
    `CHK("supervision", 1'h0, rdat[14])
    i_peer.status(6'h01, 3'h5);
    wt(10010);
    `CHK("link_fail", 1'h1, lfail)
    give_verdict();
  end
endmodule

//--- rtl/slmon_pkg.sv
// Constants and types shared by the signalling link error monitor.
package slmon_pkg;
  localparam int CLK_KHZ = 10000;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONG = 8'h08;
  localparam int CTRL_PCR = 0;
  localparam int CTRL_HIGH = 1;
  localparam int CTRL_EMERG = 2;
  localparam int CTRL_INSERV = 3;
  localparam int CTRL_ALIGN = 4;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [15:0] CONG_RST = 16'h2040;
  localparam logic [6:0] UNIT_ERROR_RATE_MONITOR_T_HIGH = 7'h40;
  localparam logic [6:0] UNIT_ERROR_RATE_MONITOR_T_LOW = 7'h20;
  localparam logic [8:0] LEAK_D = 9'h100;
  localparam logic [8:0] OCTET_N = 9'h010;
  localparam logic [2:0] AERM_TIN = 3'h4;
  localparam logic [2:0] AERM_TIE = 3'h1;
  localparam logic [2:0] ABORT_M = 3'h5;
  localparam logic [5:0] LI_ONE = 6'h01;
  localparam logic [5:0] LI_TWO = 6'h02;

  typedef enum logic [2:0] {
    ST_O = 3'b000, ST_N = 3'b001, ST_E = 3'b010, ST_OS = 3'b011,
    ST_PO = 3'b100, ST_B = 3'b101, ST_SP6 = 3'b110, ST_SP7 = 3'b111
  } slmon_status_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_FLAG = 3'b001, TX_FISU = 3'b010, TX_NEW = 3'b011,
    TX_UNACK = 3'b100, TX_NACK = 3'b101, TX_LSSU = 3'b110, TX_REPEAT = 3'b111
  } slmon_tx_sel_t;

  typedef enum logic [1:0] {
    PRV_IDLE = 2'b00, PRV_RUN = 2'b01, PRV_ABORT = 2'b10, PRV_OOS = 2'b11
  } slmon_prv_t;

  typedef struct packed {
    logic valid;
    logic [5:0] li;
    logic [15:0] sf;
  } slmon_lssu_t;

  typedef struct packed {
    logic lssu;
    logic repeat_msu;
    logic nack_msu;
    logic new_msu;
    logic unacked_msu;
    logic fisu;
    logic flags_only;
    logic silent;
  } slmon_tx_req_t;

  typedef struct packed {
    logic [5:0] spare_hi;
    slmon_status_t last;
    logic [2:0] aborts;
    logic [2:0] aerm;
    logic octet_mode;
    logic busy_pend;
    logic remote_busy;
    logic congested;
    logic oos;
    logic link_fail;
    logic excess;
    logic [2:0] spare_lo;
    logic [6:0] unit_error_rate_monitor;
  } slmon_stat_reg_t;
endpackage

//--- rtl/slmon_step.sv
// Event divider that pulses once every programmed number of events.
`timescale 1ns/1ns
module slmon_step import slmon_pkg::*; #(
  parameter int W = 9
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_event,
  input wire logic [W-1:0] i_step,
  output logic o_tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (i_clear) begin
      next_cnt = '0;
    end else if (i_event) begin
      if (cnt == i_step - W'(1)) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule

//--- rtl/slmon_top.sv
// Signalling link error monitor, congestion handling and transmit selector.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module slmon_top import slmon_pkg::*; #(
  parameter int BUSY_REPEAT_MS = 100,
  parameter int CONG_SUP_MS = 3000,
  parameter int UNIT_LIMIT = 127,
  parameter int OCTET_LIMIT = 4096
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_su_good,
  input wire logic i_su_error,
  input wire logic i_octet,
  input wire logic i_loss_align,
  input wire logic i_proving_enter,
  input wire logic i_period_expired,
  input wire slmon_lssu_t i_lssu,
  input wire logic i_ack_valid,
  input wire logic i_ack_positive,
  input wire logic i_ack_covers,
  input wire logic [7:0] i_rx_fill,
  input wire logic i_tx_slot,
  input wire slmon_tx_req_t i_tx_req,
  input wire logic [15:0] i_rtb_units,
  input wire logic [15:0] i_rtb_octets,
  output slmon_tx_sel_t o_tx_sel,
  output logic o_excess_error,
  output logic o_link_fail,
  output logic o_out_of_service,
  output logic o_proving_abort,
  output logic o_proving_restart,
  output logic o_proving_ok,
  output slmon_status_t o_rx_status,
  output logic o_rx_status_valid,
  output logic o_congested
);
  localparam int BUSY_CYC = (BUSY_REPEAT_MS * CLK_KHZ < 1) ? 1 : BUSY_REPEAT_MS * CLK_KHZ;
  localparam int SUP_CYC = (CONG_SUP_MS * CLK_KHZ < 1) ? 1 : CONG_SUP_MS * CLK_KHZ;

  logic [2:0] ctrl, next_ctrl;
  logic [15:0] cong_cfg, next_cong_cfg;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic octet_mode, next_octet_mode;
  logic [6:0] unit_error_rate_monitor_cnt, next_unit_error_rate_monitor_cnt;
  logic next_excess;
  slmon_prv_t prv_state, next_prv_state;
  logic [2:0] aerm_cnt, next_aerm_cnt;
  logic [2:0] abort_cnt, next_abort_cnt;
  logic bad_status, next_bad_status;
  logic next_abort, next_restart, next_ok, next_oos;
  slmon_status_t next_rx_status;
  logic next_rx_valid;
  logic next_congested;
  logic [31:0] busy_tmr, next_busy_tmr;
  logic busy_pend, next_busy_pend;
  logic sup_run, next_sup_run;
  logic [31:0] sup_tmr, next_sup_tmr;
  logic next_link_fail;
  slmon_tx_sel_t next_tx_sel;
  logic setup, wr_en, inserv, align, oct_tick, leak_tick, inc, lssu_ok, lssu_want, forced;
  logic [6:0] unit_error_rate_monitor_thr;
  logic [2:0] ti;
  slmon_stat_reg_t stat;
  slmon_status_t dec_status;

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
  assign inserv = wr_en && i_paddr == REG_CTRL && i_pwdata[CTRL_INSERV];
  assign align = wr_en && i_paddr == REG_CTRL && i_pwdata[CTRL_ALIGN];
  assign unit_error_rate_monitor_thr = ctrl[CTRL_HIGH] ? UNIT_ERROR_RATE_MONITOR_T_HIGH : UNIT_ERROR_RATE_MONITOR_T_LOW;
  assign ti = ctrl[CTRL_EMERG] ? AERM_TIE : AERM_TIN;
  assign inc = octet_mode ? oct_tick : i_su_error;
  assign dec_status = slmon_status_t'(i_lssu.sf[2:0]);
  assign lssu_ok = i_lssu.valid && (i_lssu.li == LI_ONE || i_lssu.li == LI_TWO);
  assign lssu_want = i_tx_req.lssu || busy_pend;
  assign forced = i_tx_req.unacked_msu && (i_rtb_units > 16'(UNIT_LIMIT) ||
                  i_rtb_octets > 16'(OCTET_LIMIT));

  always_comb begin
    stat = '0;
    stat.unit_error_rate_monitor = unit_error_rate_monitor_cnt;
    stat.excess = o_excess_error;
    stat.link_fail = o_link_fail;
    stat.oos = o_out_of_service;
    stat.congested = o_congested;
    stat.remote_busy = sup_run;
    stat.busy_pend = busy_pend;
    stat.octet_mode = octet_mode;
    stat.aerm = aerm_cnt;
    stat.aborts = abort_cnt;
    stat.last = o_rx_status;
  end

  slmon_step #(.W(9)) u_octet_step (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clear(!octet_mode),
    .i_event(i_octet),
    .i_step(OCTET_N),
    .o_tick(oct_tick)
  );

  slmon_step #(.W(9)) u_leak_step (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clear(inserv),
    .i_event(i_su_good || i_su_error),
    .i_step(LEAK_D),
    .o_tick(leak_tick)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_cong_cfg = cong_cfg;
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = '0;
    if (setup) begin
      unique case (i_paddr)
        REG_CTRL: next_prdata = {29'h0000_0000, ctrl};
        REG_STATUS: next_prdata = stat;
        REG_CONG: next_prdata = {16'h0000, cong_cfg};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr_en && i_paddr == REG_CTRL) begin
      next_ctrl = i_pwdata[2:0];
    end
    if (wr_en && i_paddr == REG_CONG) begin
      next_cong_cfg = i_pwdata[15:0];
    end
  end

  always_comb begin
    next_octet_mode = octet_mode;
    if (i_su_good) begin
      next_octet_mode = 1'b0;
    end
    if (i_loss_align) begin
      next_octet_mode = 1'b1;
    end
    next_unit_error_rate_monitor_cnt = unit_error_rate_monitor_cnt;
    next_excess = o_excess_error;
    if (inserv) begin
      next_unit_error_rate_monitor_cnt = '0;
      next_excess = 1'b0;
    end else begin
      if (inc && !leak_tick && unit_error_rate_monitor_cnt < unit_error_rate_monitor_thr) begin
        next_unit_error_rate_monitor_cnt = unit_error_rate_monitor_cnt + 7'h01;
      end else if (leak_tick && !inc && unit_error_rate_monitor_cnt != 7'h00) begin
        next_unit_error_rate_monitor_cnt = unit_error_rate_monitor_cnt - 7'h01;
      end
      if (next_unit_error_rate_monitor_cnt >= unit_error_rate_monitor_thr) begin
        next_excess = 1'b1;
      end
    end
  end

  always_comb begin
    next_prv_state = prv_state;
    next_aerm_cnt = aerm_cnt;
    next_abort_cnt = abort_cnt;
    next_bad_status = bad_status;
    next_oos = o_out_of_service;
    next_abort = 1'b0;
    next_restart = 1'b0;
    next_ok = 1'b0;
    unique case (prv_state)
      PRV_IDLE: begin
        if (i_proving_enter) begin
          next_prv_state = PRV_RUN;
          next_aerm_cnt = '0;
          next_bad_status = 1'b0;
        end
      end
      PRV_RUN: begin
        if (inc) begin
          next_aerm_cnt = aerm_cnt + 3'h1;
        end
        if (lssu_ok && (dec_status == ST_O || dec_status == ST_OS)) begin
          next_bad_status = 1'b1;
        end
        if (i_proving_enter) begin
          next_aerm_cnt = '0;
          next_bad_status = 1'b0;
        end else if (next_aerm_cnt >= ti) begin
          next_abort = 1'b1;
          next_abort_cnt = abort_cnt + 3'h1;
          if (abort_cnt + 3'h1 == ABORT_M) begin
            next_prv_state = PRV_OOS;
            next_oos = 1'b1;
          end else begin
            next_prv_state = PRV_ABORT;
          end
        end else if (i_period_expired) begin
          next_ok = !next_bad_status && !o_excess_error;
          next_prv_state = PRV_IDLE;
        end
      end
      PRV_ABORT: begin
        if (i_su_good || i_period_expired) begin
          next_restart = 1'b1;
          next_prv_state = PRV_RUN;
          next_aerm_cnt = '0;
          next_bad_status = 1'b0;
        end
      end
      PRV_OOS: begin
        next_prv_state = PRV_OOS;
      end
    endcase
    if (align) begin
      next_prv_state = PRV_IDLE;
      next_abort_cnt = '0;
      next_oos = 1'b0;
    end
  end

  always_comb begin
    next_rx_status = o_rx_status;
    next_rx_valid = lssu_ok;
    if (lssu_ok) begin
      next_rx_status = dec_status;
    end
    next_sup_run = sup_run;
    next_sup_tmr = sup_tmr;
    next_link_fail = o_link_fail && !align;
    if (sup_run) begin
      if (sup_tmr == 32'h0000_0000) begin
        next_sup_run = 1'b0;
        next_link_fail = 1'b1;
      end else begin
        next_sup_tmr = sup_tmr - 32'h0000_0001;
      end
    end
    if (i_ack_valid && (ctrl[CTRL_PCR] ? i_ack_positive : i_ack_covers)) begin
      next_sup_run = 1'b0;
    end
    if (lssu_ok && dec_status == ST_B && !sup_run) begin
      next_sup_run = 1'b1;
      next_sup_tmr = 32'(SUP_CYC - 1);
    end
  end

  always_comb begin
    next_congested = o_congested;
    next_busy_tmr = busy_tmr;
    next_busy_pend = busy_pend;
    next_tx_sel = o_tx_sel;
    if (!o_congested && i_rx_fill >= cong_cfg[7:0]) begin
      next_congested = 1'b1;
    end else if (o_congested && i_rx_fill <= cong_cfg[15:8]) begin
      next_congested = 1'b0;
    end
    if (i_tx_slot) begin
      if (i_tx_req.silent) begin
        next_tx_sel = TX_IDLE;
      end else if (i_tx_req.flags_only) begin
        next_tx_sel = TX_FLAG;
      end else if (lssu_want) begin
        next_tx_sel = TX_LSSU;
        next_busy_pend = 1'b0;
      end else if (ctrl[CTRL_PCR]) begin
        if (forced) begin
          next_tx_sel = TX_UNACK;
        end else if (i_tx_req.new_msu) begin
          next_tx_sel = TX_NEW;
        end else if (i_tx_req.unacked_msu) begin
          next_tx_sel = TX_UNACK;
        end else if (i_tx_req.fisu) begin
          next_tx_sel = TX_FISU;
        end else begin
          next_tx_sel = TX_FLAG;
        end
      end else if (i_tx_req.repeat_msu) begin
        next_tx_sel = TX_REPEAT;
      end else if (i_tx_req.nack_msu) begin
        next_tx_sel = TX_NACK;
      end else if (i_tx_req.new_msu) begin
        next_tx_sel = TX_NEW;
      end else if (i_tx_req.fisu) begin
        next_tx_sel = TX_FISU;
      end else begin
        next_tx_sel = TX_FLAG;
      end
    end
    if (!o_congested && next_congested) begin
      next_busy_pend = 1'b1;
      next_busy_tmr = 32'(BUSY_CYC - 1);
    end else if (o_congested && !next_congested) begin
      next_busy_pend = 1'b0;
    end else if (o_congested) begin
      if (busy_tmr == 32'h0000_0000) begin
        next_busy_pend = 1'b1;
        next_busy_tmr = 32'(BUSY_CYC - 1);
      end else begin
        next_busy_tmr = busy_tmr - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RST;
      cong_cfg <= CONG_RST;
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      octet_mode <= 1'b0;
      unit_error_rate_monitor_cnt <= '0;
      o_excess_error <= 1'b0;
      prv_state <= PRV_IDLE;
      aerm_cnt <= '0;
      abort_cnt <= '0;
      bad_status <= 1'b0;
      o_out_of_service <= 1'b0;
      o_proving_abort <= 1'b0;
      o_proving_restart <= 1'b0;
      o_proving_ok <= 1'b0;
      o_rx_status <= ST_O;
      o_rx_status_valid <= 1'b0;
      sup_run <= 1'b0;
      sup_tmr <= '0;
      o_link_fail <= 1'b0;
      o_congested <= 1'b0;
      busy_tmr <= '0;
      busy_pend <= 1'b0;
      o_tx_sel <= TX_IDLE;
    end else begin
      ctrl <= next_ctrl;
      cong_cfg <= next_cong_cfg;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      octet_mode <= next_octet_mode;
      unit_error_rate_monitor_cnt <= next_unit_error_rate_monitor_cnt;
      o_excess_error <= next_excess;
      prv_state <= next_prv_state;
      aerm_cnt <= next_aerm_cnt;
      abort_cnt <= next_abort_cnt;
      bad_status <= next_bad_status;
      o_out_of_service <= next_oos;
      o_proving_abort <= next_abort;
      o_proving_restart <= next_restart;
      o_proving_ok <= next_ok;
      o_rx_status <= next_rx_status;
      o_rx_status_valid <= next_rx_valid;
      sup_run <= next_sup_run;
      sup_tmr <= next_sup_tmr;
      o_link_fail <= next_link_fail;
      o_congested <= next_congested;
      busy_tmr <= next_busy_tmr;
      busy_pend <= next_busy_pend;
      o_tx_sel <= next_tx_sel;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  unit_error_rate_monitor_sat_a: assert property (unit_error_rate_monitor_cnt <= UNIT_ERROR_RATE_MONITOR_T_HIGH)
    else $error("Unit error count above the highest threshold.");
  leak_step_a: assert property (leak_tick && !inc && !inserv && unit_error_rate_monitor_cnt != 7'h00
    |=> unit_error_rate_monitor_cnt == $past(unit_error_rate_monitor_cnt) - 7'h01)
    else $error("Leak tick did not lower the unit error count.");
  excess_flag_a: assert property (unit_error_rate_monitor_cnt >= unit_error_rate_monitor_thr |-> ##[0:1] o_excess_error)
    else $error("Threshold reached without excessive error flag.");
  octet_inc_a: assert property (octet_mode && oct_tick && !leak_tick && !inserv
    && unit_error_rate_monitor_cnt < unit_error_rate_monitor_thr |=> unit_error_rate_monitor_cnt == $past(unit_error_rate_monitor_cnt) + 7'h01)
    else $error("Octet step did not raise the unit error count.");
  inserv_clear_a: assert property (inserv |=> unit_error_rate_monitor_cnt == 7'h00 && !o_excess_error)
    else $error("In-service did not clear the unit error monitor.");
  aerm_clear_a: assert property (i_proving_enter && prv_state == PRV_IDLE && !align
    |=> aerm_cnt == 3'h0 && prv_state == PRV_RUN)
    else $error("Proving entry did not clear the alignment count.");
  run_below_ti_a: assert property (prv_state == PRV_RUN |-> aerm_cnt < ti)
    else $error("Proving running with alignment count at threshold.");
  abort_state_a: assert property (o_proving_abort |-> prv_state inside {PRV_ABORT, PRV_OOS})
    else $error("Abort pulse without aborted proving state.");
  oos_count_a: assert property ($rose(o_out_of_service) |-> abort_cnt == ABORT_M)
    else $error("Out of service without five aborts.");
  prove_ok_a: assert property (o_proving_ok |-> !$past(o_excess_error))
    else $error("Proving passed during excessive error rate.");
  status_dec_a: assert property (o_rx_status_valid
    |-> o_rx_status == slmon_status_t'($past(i_lssu.sf[2:0])))
    else $error("Status decode did not follow the first octet.");
  busy_stop_a: assert property (!o_congested |-> ##1 !busy_pend || o_congested)
    else $error("Busy status still pending after congestion ended.");
  link_fail_a: assert property (sup_run && sup_tmr == 32'h0000_0000 && !align
    |=> o_link_fail)
    else $error("Supervision expiry did not raise link failure.");
  lssu_first_a: assert property (i_tx_slot && !i_tx_req.silent && !i_tx_req.flags_only
    && i_tx_req.lssu |=> o_tx_sel == TX_LSSU)
    else $error("Link status unit not given top priority.");

  excess_c: cover property (o_excess_error);
  abort_c: cover property (o_proving_abort);
  ok_c: cover property (o_proving_ok);
  fail_c: cover property (o_link_fail);
endmodule
